// file: pad_board.sv
`timescale 1ns/1ps
module pad_board (
	// pad drive from the device
	input wire logic [15:0] pad_out, pad_oe, pad_pull_up,
	// board drive where the device lets go
	input wire logic [15:0] ext_level,
	output logic [15:0] pad_in
);
	assign pad_in = pad_oe & pad_out | ~pad_oe & (pad_pull_up | ext_level);
endmodule

// file: pad_ctl_decode.sv
`timescale 1ns/1ps
module pad_ctl_decode (
	// state
	input wire pad_state_pkg::reset_phase_t phase,
	input wire pad_state_pkg::op_mode_t mode,
	input wire logic standby_pin_level_bit,
	input wire pad_state_pkg::pad_func_t [pad_state_pkg::num_pads-1:0] func,
	input wire logic [pad_state_pkg::num_pads-1:0] port_oe,
	input wire logic [pad_state_pkg::num_pads-1:0] periph_oe,
	// controls
	pad_ctl_if.decoder ctl
);
	logic standby;
	logic in_reset;
	logic main_stop;
	logic sub_stop;

	assign standby = (mode == pad_state_pkg::md_sub_timer) || (mode == pad_state_pkg::md_lowcr_timer)
		|| (mode == pad_state_pkg::md_main_timer) || (mode == pad_state_pkg::md_rtc)
		|| (mode == pad_state_pkg::md_stop);
	assign in_reset = phase != pad_state_pkg::ph_active;
	assign main_stop = (mode == pad_state_pkg::md_sub_timer) || (mode == pad_state_pkg::md_lowcr_timer)
		|| (mode == pad_state_pkg::md_rtc) || (mode == pad_state_pkg::md_stop);
	assign sub_stop = mode == pad_state_pkg::md_stop;

	always_comb begin
		for (int i = 0; i < pad_state_pkg::num_pads; i++) begin
			ctl.oe[i] = 1'b0;
			ctl.pull_up[i] = 1'b0;
			ctl.in_en[i] = 1'b0;
			ctl.analog_en[i] = 1'b0;
			ctl.hold[i] = 1'b0;
			case (func[i])
				pad_state_pkg::fn_ext_reset: begin
					ctl.pull_up[i] = 1'b1;
					ctl.in_en[i] = 1'b1;
				end
				pad_state_pkg::fn_osc_in: ctl.in_en[i] = 1'b1;
				pad_state_pkg::fn_osc_out: begin
					if (!in_reset && !(i == pad_state_pkg::sub_osc_pad ? sub_stop : main_stop)) begin
						ctl.in_en[i] = 1'b1;
						ctl.hold[i] = 1'b1;
					end
				end
				pad_state_pkg::fn_analog: ctl.analog_en[i] = phase != pad_state_pkg::ph_power_on;
				pad_state_pkg::fn_debug: begin
					if (phase == pad_state_pkg::ph_power_on) begin
						ctl.in_en[i] = 1'b0;
					end else if (in_reset) begin
						ctl.pull_up[i] = 1'b1;
						ctl.in_en[i] = 1'b1;
					end else begin
						ctl.hold[i] = 1'b1;
						ctl.in_en[i] = 1'b1;
						ctl.oe[i] = periph_oe[i];
					end
				end
				pad_state_pkg::fn_ext_irq: begin
					if (!in_reset) begin
						ctl.hold[i] = 1'b1;
						ctl.in_en[i] = 1'b1;
					end
				end
				pad_state_pkg::fn_periph: begin
					if (in_reset) begin
						ctl.in_en[i] = phase != pad_state_pkg::ph_power_on;
					end else if (!(standby && standby_pin_level_bit)) begin
						ctl.hold[i] = 1'b1;
						ctl.in_en[i] = 1'b1;
						ctl.oe[i] = periph_oe[i];
					end
				end
				pad_state_pkg::fn_port: begin
					if (!in_reset && !(standby && standby_pin_level_bit)) begin
						ctl.hold[i] = 1'b1;
						ctl.in_en[i] = 1'b1;
						ctl.oe[i] = port_oe[i];
					end
				end
				default: ctl.in_en[i] = 1'b0;
			endcase
		end
	end
endmodule

// file: pad_ctl_if.sv
`timescale 1ns/1ps
interface pad_ctl_if;
	logic [pad_state_pkg::num_pads-1:0] oe;
	logic [pad_state_pkg::num_pads-1:0] pull_up;
	logic [pad_state_pkg::num_pads-1:0] in_en;
	logic [pad_state_pkg::num_pads-1:0] analog_en;
	logic [pad_state_pkg::num_pads-1:0] hold;
	modport decoder (output oe, pull_up, in_en, analog_en, hold);
	modport user (input oe, pull_up, in_en, analog_en, hold);
endinterface

// file: pad_state_control.sv
`timescale 1ns/1ps
module pad_state_control (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// reset and mode state
	input wire logic por_lvd_reset,
	input wire logic external_reset_input_n,
	input wire logic internal_reset,
	input wire pad_state_pkg::op_mode_t mode,
	input wire logic standby_pin_level_bit,
	// pin function selection
	input wire pad_state_pkg::pad_func_t [pad_state_pkg::num_pads-1:0] func,
	// internal drive
	input wire logic [pad_state_pkg::num_pads-1:0] port_out,
	input wire logic [pad_state_pkg::num_pads-1:0] port_oe,
	input wire logic [pad_state_pkg::num_pads-1:0] periph_out,
	input wire logic [pad_state_pkg::num_pads-1:0] periph_oe,
	// pads
	input wire logic [pad_state_pkg::num_pads-1:0] pad_in,
	output logic [pad_state_pkg::num_pads-1:0] pad_out,
	output logic [pad_state_pkg::num_pads-1:0] pad_oe,
	output logic [pad_state_pkg::num_pads-1:0] pad_pull_up,
	output logic [pad_state_pkg::num_pads-1:0] pad_analog_en,
	// to internal logic
	output logic [pad_state_pkg::num_pads-1:0] core_in
);
	pad_state_pkg::reset_phase_t phase;
	logic [pad_state_pkg::num_pads-1:0] last_out;
	pad_ctl_if ctl ();

	function automatic logic is_awake(input pad_state_pkg::op_mode_t m);
		return m == pad_state_pkg::md_run || m == pad_state_pkg::md_sleep;
	endfunction

	always_comb begin
		if (por_lvd_reset) begin
			phase = pad_state_pkg::ph_power_on;
		end else if (!external_reset_input_n) begin
			phase = pad_state_pkg::ph_ext_reset;
		end else if (internal_reset) begin
			phase = pad_state_pkg::ph_int_reset;
		end else begin
			phase = pad_state_pkg::ph_active;
		end
	end

	pad_ctl_decode decode (
		.phase(phase),
		.mode(mode),
		.standby_pin_level_bit(standby_pin_level_bit),
		.func(func),
		.port_oe(port_oe),
		.periph_oe(periph_oe),
		.ctl(ctl)
	);

	// last driven port level, frozen in standby
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_out <= '0;
		end else begin
			for (int i = 0; i < pad_state_pkg::num_pads; i++) begin
				if (ctl.hold[i] && is_awake(mode)) begin
					last_out[i] <= port_out[i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_out <= '0;
			pad_oe <= '0;
			pad_pull_up <= '0;
			pad_analog_en <= '0;
			core_in <= '0;
		end else begin
			for (int i = 0; i < pad_state_pkg::num_pads; i++) begin
				pad_oe[i] <= ctl.oe[i];
				pad_pull_up[i] <= ctl.pull_up[i];
				pad_analog_en[i] <= ctl.analog_en[i];
				core_in[i] <= ctl.in_en[i] & pad_in[i];
				if (func[i] == pad_state_pkg::fn_port) begin
					pad_out[i] <= is_awake(mode) ? port_out[i] : last_out[i];
				end else begin
					pad_out[i] <= periph_out[i];
				end
			end
		end
	end
endmodule

// file: pad_state_control_test.sv
`timescale 1ns/1ps
module pad_state_control_test;
	logic ref_clk = 0;
	logic arst_n = 0;
	logic por_lvd_reset, external_reset_input_n, internal_reset, standby_pin_level_bit;
	pad_state_pkg::op_mode_t mode;
	pad_state_pkg::pad_func_t [15:0] func;
	logic [15:0] port_out, port_oe, periph_out, periph_oe, ext_level, pad_in;
	logic [15:0] pad_out, pad_oe, pad_pull_up, pad_analog_en, core_in;
	int fail_count = 0;
	int check_count = 0;
	pad_state_control dut (.*);
	pad_board board (.*);
	initial forever #10 ref_clk = ~ref_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// function, mode, level bit, {por, ext reset pin, internal reset}
	task automatic go(input int f, input int m, input logic b, input logic [2:0] r);
		foreach (func[i]) func[i] = pad_state_pkg::pad_func_t'(f);
		mode = pad_state_pkg::op_mode_t'(m);
		standby_pin_level_bit = b;
		{por_lvd_reset, external_reset_input_n, internal_reset} = r;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic t_port;
		port_oe = 16'hffff;
		port_out = 16'ha5c3;
		go(0, 0, 1, 3'h2);
		chk(pad_oe & pad_out, 16'ha5c3);
		port_out = 16'h0000;
		go(0, 6, 0, 3'h2);
		chk(pad_out, 16'ha5c3);
		for (int m = 2; m < 7; m++) begin
			go(0, m, 1, 3'h2);
			chk(pad_oe | core_in, 16'h0000);
		end
		go(0, 0, 0, 3'h3);
		chk(pad_oe, 16'h0000);
		port_out = 16'h3c3c;
		go(0, 1, 1, 3'h2);
		chk(pad_oe & pad_out, 16'h3c3c);
		$display("port test done");
	endtask
	task automatic t_fixed;
		logic [2:0] r[4] = '{3'h4, 3'h0, 3'h3, 3'h2};
		foreach (r[i]) begin
			go(3, 6, 1, r[i]);
			chk(pad_pull_up & core_in, 16'hffff);
			go(1, 6, 1, r[i]);
			chk(core_in, ext_level);
		end
		$display("fixed pin test done");
	endtask
	task automatic t_wake;
		go(2, 5, 0, 3'h2);
		chk(pad_oe | core_in, ext_level & (16'h0001 << pad_state_pkg::sub_osc_pad));
		go(2, 4, 0, 3'h2);
		chk(pad_oe | core_in, ext_level);
		go(2, 6, 0, 3'h2);
		chk(pad_oe | core_in, 16'h0000);
		go(4, 6, 1, 3'h2);
		chk(core_in, ext_level);
		$display("wake test done");
	endtask
	task automatic t_reset_fn;
		go(5, 0, 0, 3'h4);
		chk(pad_oe | pad_pull_up, 16'h0000);
		go(5, 0, 0, 3'h0);
		chk(pad_pull_up & core_in, 16'hffff);
		go(6, 0, 0, 3'h3);
		chk(pad_analog_en & ~pad_oe & ~core_in, 16'hffff);
		go(7, 0, 0, 3'h0);
		chk(core_in, ext_level);
		$display("reset function test done");
	endtask
	task automatic t_periph;
		periph_oe = 16'hffff;
		periph_out = 16'h3c96;
		go(7, 0, 0, 3'h2);
		chk(pad_oe & pad_out, 16'h3c96);
		go(7, 6, 1, 3'h2);
		chk(pad_oe | core_in, 16'h0000);
		go(5, 6, 1, 3'h2);
		chk(pad_oe & pad_out, 16'h3c96);
		$display("peripheral test done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{port_out, port_oe, periph_out, periph_oe} = '0;
		ext_level = 16'h5a5a;
		go(0, 0, 0, 3'h2);
		repeat (3) @(posedge ref_clk);
		#1;
		arst_n = 1;
		t_port();
		t_fixed();
		t_wake();
		t_reset_fn();
		t_periph();
		complete_run();
	end
	initial begin
		#4000;
		fail_count++;
		complete_run();
	end
endmodule

// file: pad_state_pkg.sv
// Functional notes
// - plain port pins in timer/rtc/stop go hi-z, input low, when level bit set; else hold
// - a high-impedance pin has its output driver fully disabled
// - forced input presents constant low internally regardless of pin level
// - held pins follow a running peripheral; port pins keep last driven output
// - during any reset phase port configuration is ignored; reset state applies
// - external reset pin always pulled up with input enabled
// - oscillator or external clock input pins always keep input enabled
// - main oscillator output stops in sub timer, lowcr timer, rtc, stop modes
// - sub oscillator output stops only in stop mode
// - external interrupt and nmi pins hold state in standby despite level bit
// - debug pins hi-z at power-on, pulled up in resets, hold otherwise
// - analog pins hi-z always; input forced low, analog path enabled after power-on
// - other peripheral pins hi-z power-on, input enabled in resets, hi-z input low in standby when level bit set, hold otherwise
package pad_state_pkg;
	localparam int num_pads = 16;
	// pad whose oscillator output belongs to the sub oscillator
	localparam int sub_osc_pad = 1;

	typedef enum logic [2:0] {
		fn_port,
		fn_osc_in,
		fn_osc_out,
		fn_ext_reset,
		fn_ext_irq,
		fn_debug,
		fn_analog,
		fn_periph
	} pad_func_t;

	typedef enum logic [2:0] {
		md_run,
		md_sleep,
		md_sub_timer,
		md_lowcr_timer,
		md_main_timer,
		md_rtc,
		md_stop
	} op_mode_t;

	typedef enum logic [1:0] {
		ph_power_on,
		ph_ext_reset,
		ph_int_reset,
		ph_active
	} reset_phase_t;

	localparam logic [0:0] pad_hold_rst = 1'h0;
endpackage

// file: pad_state_sva.sv
`timescale 1ns/1ps
module pad_state_sva (
	input wire logic ref_clk, arst_n, por_lvd_reset, external_reset_input_n,
	input wire logic internal_reset, standby_pin_level_bit,
	input wire pad_state_pkg::op_mode_t mode,
	input wire pad_state_pkg::pad_func_t [15:0] func,
	input wire logic [15:0] port_out, port_oe, pad_in, pad_out,
	input wire logic [15:0] pad_oe, pad_pull_up, pad_analog_en, core_in
);
	wire rst = por_lvd_reset | !external_reset_input_n | internal_reset;
	wire sb = !rst & mode > 3'h1;
	wire [2:0] f = func[0];
	localparam int sub_pad = pad_state_pkg::sub_osc_pad;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	property p_lvl; sb & standby_pin_level_bit & f == 0 |=> !pad_oe[0] & !core_in[0]; endproperty
	a_lvl: assert property (p_lvl) else $error("port not released");
	property p_run; !rst & !sb & f == 0 |=> pad_oe[0] == $past(port_oe[0])
		& (!pad_oe[0] | pad_out[0] == $past(port_out[0])); endproperty
	a_run: assert property (p_run) else $error("port drive lost");
	property p_rst; rst & f == 0 |=> !pad_oe[0]; endproperty
	a_rst: assert property (p_rst) else $error("port driven in reset");
	property p_xr; f == 3 |=> pad_pull_up[0] & core_in[0] == $past(pad_in[0]); endproperty
	a_xr: assert property (p_xr) else $error("reset pin wrong");
	property p_osc; f == 1 |=> core_in[0] == $past(pad_in[0]); endproperty
	a_osc: assert property (p_osc) else $error("clock input gated");
	property p_oo; f == 2 & sb & mode != 3'h4 |=> !pad_oe[0] & !core_in[0]; endproperty
	a_oo: assert property (p_oo) else $error("osc output active");
	property p_so; func[sub_pad] == pad_state_pkg::fn_osc_out & !rst & mode == pad_state_pkg::md_stop
		|=> !pad_oe[sub_pad] & !core_in[sub_pad]; endproperty
	a_so: assert property (p_so) else $error("sub osc output active");
	property p_sh; func[sub_pad] == pad_state_pkg::fn_osc_out & !rst & mode == pad_state_pkg::md_rtc
		|=> core_in[sub_pad] == $past(pad_in[sub_pad]); endproperty
	a_sh: assert property (p_sh) else $error("sub osc output not held");
	property p_irq; sb & standby_pin_level_bit & f == 4 |=> core_in[0] == $past(pad_in[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("wake pin released");
	property p_dbg; f == 5 & !por_lvd_reset & rst |=> pad_pull_up[0]
		& core_in[0] == $past(pad_in[0]); endproperty
	a_dbg: assert property (p_dbg) else $error("debug pin wrong");
	property p_ana; f == 6 & !por_lvd_reset |=> pad_analog_en[0] & !pad_oe[0] & !core_in[0];
	endproperty
	a_ana: assert property (p_ana) else $error("analog pin wrong");
	cover property (sb & standby_pin_level_bit & f == 0);
	cover property (f == 5 & rst);
	cover property (!rst & f == 0 & port_oe[0]);
endmodule
bind pad_state_control pad_state_sva chk (.*);
